/* rtl/owm_pkg.sv */
// Constants, register map and carrier types of the single-wire bus master
package owm_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_NS = 10;

  // Standard speed times in ns
  localparam int unsigned RST_LOW_STD_NS  = 480000;
  localparam int unsigned RST_REC_STD_NS  = 480000;
  localparam int unsigned PRES_STD_NS     = 70000;
  localparam int unsigned SLOT_STD_NS     = 70000;
  localparam int unsigned W0_LOW_STD_NS   = 60000;
  localparam int unsigned W1_LOW_STD_NS   = 6000;
  localparam int unsigned SAMP_STD_NS     = 15000;
  localparam int unsigned SAMP_LATE_STD_NS = 30000;
  // Overdrive speed times in ns
  localparam int unsigned RST_LOW_OD_NS   = 48000;
  localparam int unsigned RST_REC_OD_NS   = 48000;
  localparam int unsigned PRES_OD_NS      = 8000;
  localparam int unsigned SLOT_OD_NS      = 10000;
  localparam int unsigned W0_LOW_OD_NS    = 7500;
  localparam int unsigned W1_LOW_OD_NS    = 1000;
  localparam int unsigned SAMP_OD_NS      = 2000;
  localparam int unsigned SAMP_LATE_OD_NS = 4000;
  // Line held low by someone else for this long counts as stuck
  localparam int unsigned STUCK_NS        = 960000;

  // Least time: round up; longest time: round down, never below one cycle
  function automatic int unsigned cyc_up(input int unsigned ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction : cyc_up

  function automatic int unsigned cyc_dn(input int unsigned ns);
    return (ns / CLK_NS == 0) ? 1 : ns / CLK_NS;
  endfunction : cyc_dn

  localparam int unsigned W1_LOW_STD_CYC    = cyc_dn(W1_LOW_STD_NS);
  localparam int unsigned SAMP_STD_CYC      = cyc_dn(SAMP_STD_NS);
  localparam int unsigned SAMP_LATE_STD_CYC = cyc_dn(SAMP_LATE_STD_NS);
  localparam int unsigned PRES_OD_CYC       = cyc_dn(PRES_OD_NS);
  localparam int unsigned SLOT_OD_CYC       = cyc_up(SLOT_OD_NS);
  localparam int unsigned W0_LOW_OD_CYC     = cyc_up(W0_LOW_OD_NS);
  localparam int unsigned W1_LOW_OD_CYC     = cyc_dn(W1_LOW_OD_NS);
  localparam int unsigned SAMP_OD_CYC       = cyc_dn(SAMP_OD_NS);
  localparam int unsigned SAMP_LATE_OD_CYC  = cyc_dn(SAMP_LATE_OD_NS);

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] TXDATA_OFS = 8'h08;
  localparam logic [7:0] RXDATA_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IMASK_OFS  = 8'h14;
  localparam logic [7:0] RIS_OFS    = 8'h18;
  localparam logic [7:0] MIS_OFS    = 8'h1c;
  localparam logic [7:0] ICLR_OFS   = 8'h20;
  localparam logic [7:0] DMACTL_OFS = 8'h24;

  localparam int unsigned CMD_CNT_LSB = 8;
  localparam logic [31:0] RX_RESET    = 32'hffffffff;

  // Interrupt bit positions
  localparam int unsigned IRQ_W        = 5;
  localparam int unsigned IRQ_RST_DONE = 0;
  localparam int unsigned IRQ_OP_DONE  = 1;
  localparam int unsigned IRQ_NO_PRES  = 2;
  localparam int unsigned IRQ_STUCK    = 3;
  localparam int unsigned IRQ_DMA_DONE = 4;

  localparam logic [1:0] DMA_SIZE_BYTE = 2'h0;
  localparam logic [1:0] DMA_SIZE_HALF = 2'h1;
  localparam logic [1:0] DMA_SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic dual_pin_setup;
    logic polarity_inverted;
    logic presence_check_off;
    logic sample_late;
    logic speed_overdrive;
  } cfg_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic rst;
  } op_t;

  typedef struct packed {
    logic [1:0] size;
    logic       dma_scatter_gather;
    logic       dma_chained_read;
    logic       dma_chained_write;
    logic       dma_read_each;
    logic       dma_reset_first;
  } dmactl_t;

  typedef struct packed {
    logic line_stuck_flag;
    logic no_presence_flag;
    logic line_active_flag;
  } status_t;

endpackage : owm_pkg

/* rtl/single_wire_bus_master.sv */
// Single-wire bus master with APB register slave and DMA pacing
//
// Contract
// - Reset command drives reset pulse on line
// - Active flag set while any operation runs
// - Flag missing slave when no presence seen
// - Flag line held low by another party
// - Status holds separate flags, zero when clear
// - Received bits default to one
// - Received word valid only after operations end
// - Transfers of one to four bytes, sub-byte
// - Standard and overdrive timing sets selectable
// - Read sample point normal or late
// - Presence check after reset on or off
// - Optional inverted line polarity
// - Single-pin or dual-pin line arrangement
// - Interrupts for pacing and line errors
// - DMA option issues bus reset first
// - DMA read after each transaction, request
// - DMA chained write after each write
// - DMA chained read after each read
// - Scatter-gather requests on enable and completion
// - DMA operation size 8, 16 or 32
// - Write completes before read begins
// - Programmable bit count 1 to 32
// - Five maskable, clearable sources, raw and masked
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module single_wire_bus_master
  import owm_pkg::*;
#(
  parameter int unsigned RST_LOW_STD_CYC = cyc_up(RST_LOW_STD_NS),
  parameter int unsigned RST_REC_STD_CYC = cyc_up(RST_REC_STD_NS),
  parameter int unsigned PRES_STD_CYC    = cyc_dn(PRES_STD_NS),
  parameter int unsigned SLOT_STD_CYC    = cyc_up(SLOT_STD_NS),
  parameter int unsigned W0_LOW_STD_CYC  = cyc_up(W0_LOW_STD_NS),
  parameter int unsigned RST_LOW_OD_CYC  = cyc_up(RST_LOW_OD_NS),
  parameter int unsigned RST_REC_OD_CYC  = cyc_up(RST_REC_OD_NS),
  parameter int unsigned STUCK_CYC       = cyc_up(STUCK_NS),
  parameter int unsigned CNT_W           = 20
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              dq_i,
  output logic                   dq_o,
  output logic                   dq_oe,
  input  wire logic              rx2_i,
  output logic                   irq,
  output logic                   dma_req,
  input  wire logic              dma_done
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int unsigned STUCK_W = $clog2(STUCK_CYC + 1);

  if (RST_LOW_STD_CYC >= 2**CNT_W || RST_REC_STD_CYC >= 2**CNT_W ||
      RST_LOW_OD_CYC >= 2**CNT_W || RST_REC_OD_CYC >= 2**CNT_W ||
      SLOT_STD_CYC >= 2**CNT_W || STUCK_CYC < 2 ||
      W0_LOW_STD_CYC >= SLOT_STD_CYC || SAMP_LATE_STD_CYC >= SLOT_STD_CYC ||
      PRES_STD_CYC >= RST_REC_STD_CYC || W1_LOW_STD_CYC == 0) begin : g_bad_param
    $error("single_wire_bus_master: timing parameters out of range");
  end

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_SLOT_LOW,
                            ST_SLOT_REST} state_t;

  state_t             st_q;
  cfg_t               cfg_q;
  dmactl_t            dmactl_q;
  op_t                op_q;
  op_t                pend_q;
  logic [5:0]         pend_bits_q;
  logic [5:0]         bits_q;
  logic [4:0]         bit_q;
  logic               rd_phase_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [31:0]        tx_q;
  logic [31:0]        rx_shift_q;
  logic [31:0]        rx_q;
  logic               pres_seen_q;
  logic               no_pres_q;
  logic               stuck_q;
  logic [STUCK_W-1:0] stuck_cnt_q;
  logic               drive_q;
  logic               pin_drv_q;
  logic [IRQ_W-1:0]   ris_q;
  logic [IRQ_W-1:0]   ris_d;
  logic [IRQ_W-1:0]   im_q;
  logic [31:0]        rdata_d;
  logic               hit_d;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] tsel(input logic od, input int unsigned s,
                                            input int unsigned o);
    return od ? CNT_W'(o) : CNT_W'(s);
  endfunction : tsel

  // Zero and anything past 32 fall back to a full word
  function automatic logic [5:0] fix_cnt(input logic [5:0] c);
    return (c == 6'h00 || c > 6'h20) ? 6'h20 : c;
  endfunction : fix_cnt

  function automatic logic [5:0] dma_bits(input logic [1:0] sz);
    unique case (sz)
      DMA_SIZE_BYTE: return 6'h08;
      DMA_SIZE_HALF: return 6'h10;
      default:       return 6'h20;
    endcase
  endfunction : dma_bits

  // ----------------------------------------------------------------------
  // Timing selection and line sensing
  // ----------------------------------------------------------------------
  logic             od;
  logic [CNT_W-1:0] t_rst_low;
  logic [CNT_W-1:0] t_rst_rec;
  logic [CNT_W-1:0] t_pres;
  logic [CNT_W-1:0] t_slot;
  logic [CNT_W-1:0] t_low;
  logic [CNT_W-1:0] t_samp;
  logic             line_hi;

  assign od        = cfg_q.speed_overdrive;
  assign t_rst_low = tsel(od, RST_LOW_STD_CYC, RST_LOW_OD_CYC);
  assign t_rst_rec = tsel(od, RST_REC_STD_CYC, RST_REC_OD_CYC);
  assign t_pres    = tsel(od, PRES_STD_CYC, PRES_OD_CYC);
  assign t_slot    = tsel(od, SLOT_STD_CYC, SLOT_OD_CYC);
  // Reads use the short low pulse of a one bit
  assign t_low     = (rd_phase_q || tx_q[bit_q]) ? tsel(od, W1_LOW_STD_CYC, W1_LOW_OD_CYC)
                                                 : tsel(od, W0_LOW_STD_CYC, W0_LOW_OD_CYC);
  assign t_samp    = cfg_q.sample_late ? tsel(od, SAMP_LATE_STD_CYC, SAMP_LATE_OD_CYC)
                                       : tsel(od, SAMP_STD_CYC, SAMP_OD_CYC);
  // Dual-pin setup senses on its own receive pin
  assign line_hi   = (cfg_q.dual_pin_setup ? rx2_i : dq_i)
                     ^ cfg_q.polarity_inverted;

  // ----------------------------------------------------------------------
  // Sequencer events
  // ----------------------------------------------------------------------
  logic idle;
  logic launch;
  logic last_bit;
  logic slot_end;
  logic pres_now;
  logic ev_rst_done;
  logic ev_no_pres;
  logic ev_op_done;
  logic go_read;

  assign idle        = (st_q == ST_IDLE);
  assign launch      = idle && (pend_q != '0);
  assign last_bit    = ({1'b0, bit_q} == bits_q - 6'h01);
  assign slot_end    = (st_q == ST_SLOT_REST) && (cnt_q == t_slot - 1'b1);
  assign go_read     = !rd_phase_q && op_q.rd;
  assign pres_now    = pres_seen_q || ((cnt_q == t_pres) && !line_hi);
  assign ev_rst_done = (st_q == ST_RST_WAIT) && (cnt_q == t_rst_rec - 1'b1);
  assign ev_no_pres  = ev_rst_done && !cfg_q.presence_check_off && !pres_now;
  assign ev_op_done  = slot_end && last_bit && !go_read;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic setup;
  logic wr_acc;
  logic dma_on;
  logic dma_go;
  logic cmd_take;
  logic tx_wr;

  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign tx_wr    = wr_acc && (paddr == TXDATA_OFS);
  assign cmd_take = wr_acc && (paddr == CMD_OFS) && idle && (pend_q == '0);
  assign dma_go   = wr_acc && (paddr == DMACTL_OFS) && (pwdata[4:0] != 5'h00);
  assign dma_on   = dmactl_q.dma_scatter_gather || dmactl_q.dma_chained_read ||
                    dmactl_q.dma_chained_write || dmactl_q.dma_read_each;

  always_comb begin
    rdata_d = 32'h00000000;
    hit_d   = 1'b1;
    unique case (paddr)
      CFG_OFS:    rdata_d = 32'(cfg_q);
      CMD_OFS:    rdata_d = {18'h00000, bits_q, 5'h00, op_q};
      TXDATA_OFS: rdata_d = tx_q;
      RXDATA_OFS: rdata_d = rx_q;
      STATUS_OFS: rdata_d = 32'(status_t'{stuck_q, no_pres_q, !idle || (pend_q != '0)});
      IMASK_OFS:  rdata_d = 32'(im_q);
      RIS_OFS:    rdata_d = 32'(ris_q);
      MIS_OFS:    rdata_d = 32'(ris_q & im_q);
      ICLR_OFS:   rdata_d = 32'h00000000;
      DMACTL_OFS: rdata_d = 32'(dmactl_q);
      default:    hit_d   = 1'b0;
    endcase
  end

  // Every access gets one wait-free access cycle; unmapped ones answer error
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit_d;
      prdata  <= (setup && !pwrite) ? rdata_d : 32'h00000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_q <= '0;
      im_q  <= '0;
      tx_q  <= 32'h00000000;
    end else if (wr_acc) begin
      if (paddr == CFG_OFS) cfg_q <= cfg_t'(pwdata[4:0]);
      if (paddr == IMASK_OFS) im_q <= pwdata[IRQ_W-1:0];
      if (tx_wr) tx_q <= pwdata;
    end
  end

  // ----------------------------------------------------------------------
  // DMA control
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dmactl_q <= '0;
    end else if (wr_acc && (paddr == DMACTL_OFS)) begin
      dmactl_q <= dmactl_t'(pwdata[6:0]);
    end else if (dma_done) begin
      dmactl_q <= '{size: dmactl_q.size, default: 1'b0};
    end
  end

  // Requests start only once software enables DMA, after setting it up
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= (dma_go && (pwdata[4] || pwdata[2]))
                 || (ev_op_done && dma_on);
    end
  end

  // ----------------------------------------------------------------------
  // Pending operation
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_q      <= '0;
      pend_bits_q <= 6'h20;
    end else begin
      if (launch) pend_q <= '0;
      if (cmd_take) begin
        pend_q      <= op_t'(pwdata[2:0]);
        pend_bits_q <= fix_cnt(pwdata[CMD_CNT_LSB +: 6]);
      end else if (dma_go) begin
        pend_q.rst  <= pwdata[0];
        pend_q.rd   <= pwdata[3];
        pend_bits_q <= dma_bits(pwdata[6:5]);
      end else if (tx_wr && dmactl_q.dma_chained_write) begin
        pend_q.wr   <= 1'b1;
        pend_q.rd   <= dmactl_q.dma_read_each;
        pend_bits_q <= dma_bits(dmactl_q.size);
      end else if (ev_op_done && op_q.rd && dmactl_q.dma_chained_read) begin
        pend_q.rd   <= 1'b1;
        pend_bits_q <= dma_bits(dmactl_q.size);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Line sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q        <= ST_IDLE;
      op_q        <= '0;
      bits_q      <= 6'h20;
      bit_q       <= 5'h00;
      rd_phase_q  <= 1'b0;
      cnt_q       <= '0;
      drive_q     <= 1'b0;
      pres_seen_q <= 1'b0;
      rx_shift_q  <= RX_RESET;
      rx_q        <= RX_RESET;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (launch) begin
            op_q       <= pend_q;
            bits_q     <= pend_bits_q;
            bit_q      <= 5'h00;
            cnt_q      <= '0;
            drive_q    <= 1'b1;
            rd_phase_q <= !pend_q.wr;
            rx_shift_q <= RX_RESET;
            st_q       <= pend_q.rst ? ST_RST_LOW : ST_SLOT_LOW;
          end
        end
        ST_RST_LOW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == t_rst_low - 1'b1) begin
            cnt_q       <= '0;
            drive_q     <= 1'b0;
            pres_seen_q <= 1'b0;
            st_q        <= ST_RST_WAIT;
          end
        end
        ST_RST_WAIT: begin
          cnt_q       <= cnt_q + 1'b1;
          pres_seen_q <= pres_now;
          if (ev_rst_done) begin
            cnt_q <= '0;
            if (op_q.wr || op_q.rd) begin
              drive_q <= 1'b1;
              st_q    <= ST_SLOT_LOW;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_SLOT_LOW: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == t_low - 1'b1) begin
            drive_q <= 1'b0;
            st_q    <= ST_SLOT_REST;
          end
        end
        ST_SLOT_REST: begin
          cnt_q <= cnt_q + 1'b1;
          if (rd_phase_q && cnt_q == t_samp) begin
            rx_shift_q[bit_q] <= line_hi;
          end
          if (slot_end) begin
            cnt_q <= '0;
            if (!last_bit) begin
              bit_q   <= bit_q + 5'h01;
              drive_q <= 1'b1;
              st_q    <= ST_SLOT_LOW;
            end else if (go_read) begin
              bit_q      <= 5'h00;
              rd_phase_q <= 1'b1;
              drive_q    <= 1'b1;
              st_q       <= ST_SLOT_LOW;
            end else begin
              if (rd_phase_q) rx_q <= rx_shift_q;
              st_q <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus condition flags
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      no_pres_q <= 1'b0;
    end else if (launch && pend_q.rst) begin
      no_pres_q <= 1'b0;
    end else if (ev_no_pres) begin
      no_pres_q <= 1'b1;
    end
  end

  // Own drive, and one cycle of pin lag after it, never counts as stuck
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stuck_cnt_q <= '0;
      stuck_q     <= 1'b0;
    end else if (line_hi || drive_q || pin_drv_q) begin
      stuck_cnt_q <= '0;
      if (line_hi) stuck_q <= 1'b0;
    end else if (stuck_cnt_q != STUCK_W'(STUCK_CYC - 1)) begin
      stuck_cnt_q <= stuck_cnt_q + 1'b1;
    end else begin
      stuck_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  logic [IRQ_W-1:0] ev_vec;
  logic [IRQ_W-1:0] clr_vec;

  always_comb begin
    ev_vec               = '0;
    ev_vec[IRQ_RST_DONE] = ev_rst_done;
    ev_vec[IRQ_OP_DONE]  = ev_op_done;
    ev_vec[IRQ_NO_PRES]  = ev_no_pres;
    ev_vec[IRQ_STUCK]    = (stuck_cnt_q == STUCK_W'(STUCK_CYC - 1)) && !stuck_q &&
                           !line_hi && !drive_q && !pin_drv_q;
    ev_vec[IRQ_DMA_DONE] = dma_done;
    clr_vec = (wr_acc && paddr == ICLR_OFS) ? pwdata[IRQ_W-1:0] : '0;
    ris_d   = (ris_q & ~clr_vec) | ev_vec;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ris_q <= '0;
      irq   <= 1'b0;
    end else begin
      ris_q <= ris_d;
      irq   <= |(ris_d & im_q);
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  // Single pin is open drain; the dual-pin transmit pin is driven always
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pin_drv_q <= 1'b0;
      dq_oe     <= 1'b0;
      dq_o      <= 1'b0;
    end else begin
      pin_drv_q <= drive_q;
      dq_oe     <= cfg_q.dual_pin_setup || drive_q;
      dq_o      <= drive_q ? cfg_q.polarity_inverted
                           : !cfg_q.polarity_inverted;
    end
  end

endmodule : single_wire_bus_master

`default_nettype wire

/* tb/owm_properties.sv */
// Checker: port timing properties of the single-wire bus master
`timescale 1ns/100ps
`default_nettype none
module owm_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dq_oe,
  input wire logic        dma_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_reset_quiet: assert property (disable iff (1'h0) !resetn |=> !pready && !dq_oe && !dma_req)
    else $error("outputs live in reset");
  a_dma_req_pulse: assert property (dma_req |=> !dma_req)
    else $error("dma request held");
  a_drive_min_width: assert property ($rose(dq_oe) |-> dq_oe [*8])
    else $error("line pulse too short");
  c_error: cover property (pslverr);
  c_drive: cover property ($rose(dq_oe));
  c_dma: cover property (dma_req);
endmodule : owm_checker
bind single_wire_bus_master owm_checker u_checker (.mclk, .resetn, .psel, .penable,
  .prdata, .pready, .pslverr, .dq_oe, .dma_req);
`default_nettype wire

/* tb/wire_slave.sv */
// Partner model: one slave part on the single-wire line
`timescale 1ns/100ps
`default_nettype none
module wire_slave (
  input  wire logic        mclk,
  input  wire logic        drv,
  input  wire logic        present,
  input  wire logic        rd_en,
  input  wire logic [31:0] pat,
  output logic             pull
);
  int         lo;
  int         t;
  logic [4:0] idx = 5'h0;
  // Zeros are held past the overdrive late sample point, so either setting reads them at overdrive speed only
  always @(posedge mclk) begin
    lo <= drv ? lo + 1 : 0;
    t <= (t > 0) ? t - 1 : 0;
    // Each read starts again at bit 0, however many bits the last one took
    if (!rd_en) idx <= 5'h0;
    else if (drv && lo == 0) idx <= idx + 5'h1;
    if (drv && lo == 0 && rd_en && !pat[idx]) t <= 500;
    if (!drv && lo > 50 && present) t <= 900;
  end
  assign pull = t != 0;
endmodule : wire_slave
`default_nettype wire

/* tb/tb_single_wire_bus_master.sv */
// Testbench: register-level checks of the single-wire bus master
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; $display("unexpected %0t mismatch", $time); end end
module tb_single_wire_bus_master;
  import owm_pkg::*;
  logic        mclk, resetn, psel, penable, pwrite, dma_done, present, rd_en, hold, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, rd, pat;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, dq_o, dq_oe, irq, dma_req, pull, line, mdrv;
  int          errors, cmp_count, n, n_req;
  // Pulled-up line; the dual-pin transmit pin is push-pull, so only its active level pulls
  assign mdrv = dq_oe & ~dq_o;
  assign line = ~(mdrv | pull | hold);
  always @(posedge mclk) if (dma_req === 1'h1) n_req <= n_req + 1;
  single_wire_bus_master #(.RST_LOW_OD_CYC(100), .RST_REC_OD_CYC(1000), .STUCK_CYC(3000)) u_dut (
    .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .dq_i(line), .dq_o, .dq_oe, .rx2_i(line), .irq, .dma_req, .dma_done);
  wire_slave u_slave (.mclk, .drv(mdrv), .present, .rd_en, .pat, .pull);
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge mclk) penable <= 1'h1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'h1 && k < 50);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge mclk);
    if (k == 50) begin errors++; complete_run(); end
  endtask : apb
  task automatic op(input logic [31:0] c);
    int k;
    apb(1'h1, CMD_OFS, c);
    apb(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[0], 1'h1)
    k = 0;
    do begin apb(1'h0, STATUS_OFS, 32'h0); k++; end while (rd[0] !== 1'h0 && k < 15000);
    if (k == 15000) begin errors++; complete_run(); end
  endtask : op
  function automatic logic [31:0] exp_rx(input logic [31:0] p, input int b);
    return (b == 32) ? p : p | ~((32'h1 << b) - 32'h1);
  endfunction : exp_rx
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'hcc16ea90));
    {psel, penable, pwrite, dma_done, present, rd_en, hold, paddr, pwdata, pat} = '0;
    resetn = 1'h0;
    repeat (6) @(posedge mclk);
    resetn <= 1'h1;
    @(posedge mclk);
    apb(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, RXDATA_OFS, 32'h0);
    `CHK(rd, RX_RESET)
    apb(1'h0, 8'h40, 32'h0);
    `CHK(err, 1'h1)
    apb(1'h1, CFG_OFS, 32'h1);
    present <= 1'h1;
    op(32'h1);
    `CHK(rd, 32'h0)
    present <= 1'h0;
    op(32'h1);
    `CHK(rd, 32'h2)
    apb(1'h1, CFG_OFS, 32'h5);
    op(32'h1);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, CFG_OFS, i ? 32'h13 : 32'h1);
      n = i ? $urandom_range(32, 1) : 1;
      pat = $urandom;
      rd_en <= 1'h1;
      op({18'h0, n[5:0], 8'h4});
      rd_en <= 1'h0;
      apb(1'h0, RXDATA_OFS, 32'h0);
      `CHK(rd, exp_rx(pat, n))
    end
    apb(1'h1, IMASK_OFS, 32'h2);
    apb(1'h0, MIS_OFS, 32'h0);
    `CHK(rd, 32'h2)
    `CHK(irq, 1'h1)
    apb(1'h1, ICLR_OFS, 32'h1f);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'h0)
    hold <= 1'h1;
    repeat (3500) @(posedge mclk);
    apb(1'h0, STATUS_OFS, 32'h0);
    `CHK(rd[2], 1'h1)
    hold <= 1'h0;
    apb(1'h1, DMACTL_OFS, 32'h11);
    dma_done <= 1'h1;
    @(posedge mclk) dma_done <= 1'h0;
    repeat (1200) @(posedge mclk);
    apb(1'h0, RIS_OFS, 32'h0);
    `CHK(rd[IRQ_DMA_DONE], 1'h1)
    `CHK(rd[IRQ_RST_DONE], 1'h1)
    `CHK(n_req, 1)
    complete_run();
  end
endmodule : tb_single_wire_bus_master
`default_nettype wire
